// [hdl/seb_bank.sv]
// Sticky error status bank with summary flag, alert and sleep masking
//
// How it works
// - Each detected error sets its own single status bit.
// - Summary flag is set while any bank status bit is set.
// - With alert enabled, alert output asserts whenever summary flag is set.
// - Processor-hot fixed-threshold bits never reach summary flag or alert.
// - Set bits stay set after the fault ends; only software clears them.
// - Clearing fails while the fault persists and is unmasked.
// - A masked fault bit can be cleared while the fault persists.
// - In alert-standard-format mode, read and write-one both clear bits.
// - Otherwise reads do not clear; only writing a one clears.
// - Optional sleep masks apply only when enabled; fixed ones always.
// - Register one: zones 1-4 in bits 0-3, regulators bits 4-5.
// - Zones 1, 2 optionally masked in S3 and S4/5; zones 3, 4 never.
// - Register two bit n flags voltage channel n+1 out of range.
// - All eight voltage bits are masked in S3 and S4/5.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "seb_defs.svh"

module seb_bank (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // Register bus
    input  wire seb_pkg::seb_bus_req_t bus_req,
    output logic [7:0]                rdata,
    // Error events from comparators on this clock
    input  wire seb_pkg::seb_events_t fault_events,
    // Regulator hot pins, asynchronous
    input  wire logic                 regulator1_hot_input,
    input  wire logic                 regulator2_hot_input_n,
    // Status outputs
    output logic                      error_summary_flag,
    output logic                      alert_n
);

    ////////////////////////////////////////////////////////////////////////
    // Reset image of the state
    localparam seb_pkg::seb_state_t SEB_STATE_RST = '{
        // Idle pin levels, so no false hot event follows reset
        hot_sync1:        2'b10,
        hot_sync2:        2'b10,
        alert_en:         1'((`SEB_RST_CTRL >> `SEB_BIT_ALERT_EN) & 8'h01),
        asf_mode:         1'((`SEB_RST_CTRL >> `SEB_BIT_ASF_MODE) & 8'h01),
        sleep_state:      seb_pkg::SEB_SLEEP_S0,
        s3_mask:          `SEB_RST_SLEEP_MASK,
        s45_mask:         `SEB_RST_SLEEP_MASK,
        err_mask_temp_vr: `SEB_RST_ERR_MASK,
        err_mask_volt:    `SEB_RST_ERR_MASK,
        rdata:            `SEB_RST_RDATA,
        summary:          1'b0,
        alert_n:          `SEB_ALERT_N_IDLE
    };

    localparam int TVB = `SEB_TEMP_VR_BITS;
    localparam int VB  = `SEB_VOLT_BITS;

    seb_pkg::seb_state_t state_reg;
    seb_pkg::seb_state_t state_next;

    // Decoded accesses
    logic           wr_temp_vr;
    logic           wr_volt;
    logic           rd_temp_vr;
    logic           rd_volt;

    // Sleep decode
    logic           in_s3;
    logic           in_s45;
    logic           asleep;

    // Event, mask and clear vectors of the two status registers
    logic [TVB-1:0] temp_vr_events;
    logic [TVB-1:0] temp_vr_mask;
    logic [TVB-1:0] temp_vr_clear;
    logic [TVB-1:0] temp_vr_status;
    logic [VB-1:0]  volt_mask;
    logic [VB-1:0]  volt_clear;
    logic [VB-1:0]  volt_status;

    // Bank level
    logic           bank_any;

    ////////////////////////////////////////////////////////////////////////
    // Access decode
    always_comb begin
        wr_temp_vr = bus_req.wr &&
                     (bus_req.addr == `SEB_ADDR_STATUS_TEMP_VR);
        wr_volt    = bus_req.wr &&
                     (bus_req.addr == `SEB_ADDR_STATUS_VOLT_LOW);
        rd_temp_vr = bus_req.rd &&
                     (bus_req.addr == `SEB_ADDR_STATUS_TEMP_VR);
        rd_volt    = bus_req.rd &&
                     (bus_req.addr == `SEB_ADDR_STATUS_VOLT_LOW);
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep state decode; the illegal code counts as awake
    always_comb begin
        in_s3  = 1'b0;
        in_s45 = 1'b0;
        unique case (state_reg.sleep_state)
            seb_pkg::SEB_SLEEP_S0: begin
                in_s3  = 1'b0;
                in_s45 = 1'b0;
            end
            seb_pkg::SEB_SLEEP_S3: begin
                in_s3  = 1'b1;
            end
            seb_pkg::SEB_SLEEP_S45: begin
                in_s45 = 1'b1;
            end
            default: begin
                in_s3  = 1'b0;
                in_s45 = 1'b0;
            end
        endcase
        asleep = in_s3 | in_s45;
    end

    ////////////////////////////////////////////////////////////////////////
    // Events of the temperature / regulator register
    always_comb begin
        temp_vr_events = '0;
        temp_vr_events[`SEB_BIT_ZONE1] = fault_events.zone_temp[0];
        temp_vr_events[`SEB_BIT_ZONE2] = fault_events.zone_temp[1];
        temp_vr_events[`SEB_BIT_ZONE3] = fault_events.zone_temp[2];
        temp_vr_events[`SEB_BIT_ZONE4] = fault_events.zone_temp[3];
        // Hot pins after the synchroniser; second input is active low
        temp_vr_events[`SEB_BIT_VR1] = state_reg.hot_sync2[0];
        temp_vr_events[`SEB_BIT_VR2] = ~state_reg.hot_sync2[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // Masks of the temperature / regulator register
    always_comb begin
        temp_vr_mask = state_reg.err_mask_temp_vr[TVB-1:0];
        // Zones 1 and 2: sleep masks only where the mask bit allows
        temp_vr_mask[`SEB_BIT_ZONE1] = temp_vr_mask[`SEB_BIT_ZONE1] |
            (in_s3  & state_reg.s3_mask[`SEB_BIT_MASK_ZONE1]) |
            (in_s45 & state_reg.s45_mask[`SEB_BIT_MASK_ZONE1]);
        temp_vr_mask[`SEB_BIT_ZONE2] = temp_vr_mask[`SEB_BIT_ZONE2] |
            (in_s3  & state_reg.s3_mask[`SEB_BIT_MASK_ZONE2]) |
            (in_s45 & state_reg.s45_mask[`SEB_BIT_MASK_ZONE2]);
        // Zones 3 and 4 are never sleep-masked
        temp_vr_mask[`SEB_BIT_ZONE3] =
            state_reg.err_mask_temp_vr[`SEB_BIT_ZONE3];
        temp_vr_mask[`SEB_BIT_ZONE4] =
            state_reg.err_mask_temp_vr[`SEB_BIT_ZONE4];
        // Regulator bits are masked in any sleep state
        temp_vr_mask[`SEB_BIT_VR1] = temp_vr_mask[`SEB_BIT_VR1] |
            asleep;
        temp_vr_mask[`SEB_BIT_VR2] = temp_vr_mask[`SEB_BIT_VR2] |
            asleep;
    end

    ////////////////////////////////////////////////////////////////////////
    // Voltage masks: unconditional in either sleep state
    always_comb begin
        volt_mask = state_reg.err_mask_volt | {VB{asleep}};
    end

    ////////////////////////////////////////////////////////////////////////
    // Clear requests; reads clear only in alert-standard-format mode
    always_comb begin
        temp_vr_clear = '0;
        volt_clear    = '0;
        if (wr_temp_vr) begin
            // Reserved bits 7:6 are dropped here
            temp_vr_clear = bus_req.wdata[TVB-1:0];
        end
        if (wr_volt) begin
            volt_clear = bus_req.wdata;
        end
        // Read-to-clear takes every bit; the old value is still returned
        // A live unmasked event still wins inside the sticky register
        if (rd_temp_vr && state_reg.asf_mode) begin
            temp_vr_clear = {TVB{1'b1}};
        end
        if (rd_volt && state_reg.asf_mode) begin
            volt_clear = {VB{1'b1}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky registers
    seb_sticky_reg #(
        .WIDTH (TVB)
    ) u_status_temp_vr (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .event_in (temp_vr_events),
        .mask_in  (temp_vr_mask),
        .clear_in (temp_vr_clear),
        .status   (temp_vr_status)
    );

    seb_sticky_reg #(
        .WIDTH (VB)
    ) u_status_volt_low (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .event_in (fault_events.voltage),
        .mask_in  (volt_mask),
        .clear_in (volt_clear),
        .status   (volt_status)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bank level; only these two registers feed it, no processor-hot bits
    always_comb begin
        bank_any = (|temp_vr_status) | (|volt_status);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_next = state_reg;

        // Two-flop synchroniser of the hot pins
        // Only the second stage feeds the event logic
        state_next.hot_sync1 = {regulator2_hot_input_n,
                                regulator1_hot_input};
        state_next.hot_sync2 = state_reg.hot_sync1;

        // Configuration writes
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                `SEB_ADDR_CTRL: begin
                    state_next.alert_en =
                        bus_req.wdata[`SEB_BIT_ALERT_EN];
                    state_next.asf_mode =
                        bus_req.wdata[`SEB_BIT_ASF_MODE];
                end
                `SEB_ADDR_SLEEP_STATE: begin
                    state_next.sleep_state =
                        seb_pkg::seb_sleep_t'(bus_req.wdata[1:0]);
                end
                `SEB_ADDR_S3_MASK: begin
                    state_next.s3_mask = bus_req.wdata[1:0];
                end
                `SEB_ADDR_S45_MASK: begin
                    state_next.s45_mask = bus_req.wdata[1:0];
                end
                `SEB_ADDR_ERR_MASK_TEMP_VR: begin
                    state_next.err_mask_temp_vr =
                        {2'b00, bus_req.wdata[TVB-1:0]};
                end
                `SEB_ADDR_ERR_MASK_VOLT: begin
                    state_next.err_mask_volt = bus_req.wdata;
                end
                default: begin
                    state_next.err_mask_volt = state_reg.err_mask_volt;
                end
            endcase
        end

        // Read data, present in the cycle after the strobe only
        state_next.rdata = `SEB_RST_RDATA;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `SEB_ADDR_STATUS_TEMP_VR: begin
                    // Reserved bits read as zero
                    state_next.rdata = {2'b00, temp_vr_status};
                end
                `SEB_ADDR_STATUS_VOLT_LOW: begin
                    state_next.rdata = volt_status;
                end
                `SEB_ADDR_CTRL: begin
                    state_next.rdata[`SEB_BIT_ALERT_EN] =
                        state_reg.alert_en;
                    state_next.rdata[`SEB_BIT_ASF_MODE] =
                        state_reg.asf_mode;
                    state_next.rdata[`SEB_BIT_SUMMARY] =
                        state_reg.summary;
                end
                `SEB_ADDR_SLEEP_STATE: begin
                    state_next.rdata[1:0] = state_reg.sleep_state;
                end
                `SEB_ADDR_S3_MASK: begin
                    state_next.rdata[1:0] = state_reg.s3_mask;
                end
                `SEB_ADDR_S45_MASK: begin
                    state_next.rdata[1:0] = state_reg.s45_mask;
                end
                `SEB_ADDR_ERR_MASK_TEMP_VR: begin
                    state_next.rdata = state_reg.err_mask_temp_vr;
                end
                `SEB_ADDR_ERR_MASK_VOLT: begin
                    state_next.rdata = state_reg.err_mask_volt;
                end
                default: begin
                    state_next.rdata = `SEB_RST_RDATA;
                end
            endcase
        end

        // Summary flag and alert follow the bank level together
        // Both lag the status bits by one clock
        state_next.summary = bank_any;
        state_next.alert_n = ~(state_reg.alert_en & bank_any);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg <= SEB_STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign rdata              = state_reg.rdata;
    assign error_summary_flag = state_reg.summary;
    assign alert_n            = state_reg.alert_n;

endmodule // seb_bank

`default_nettype wire

// [inc/seb_defs.svh]
// Offsets, field positions and reset values of the sticky error bank
`ifndef SEB_DEFS_SVH
`define SEB_DEFS_SVH

// Register offsets
`define SEB_ADDR_STATUS_TEMP_VR   8'h40
`define SEB_ADDR_STATUS_VOLT_LOW  8'h41
`define SEB_ADDR_CTRL             8'h50
`define SEB_ADDR_SLEEP_STATE      8'h51
`define SEB_ADDR_S3_MASK          8'h52
`define SEB_ADDR_S45_MASK         8'h53
`define SEB_ADDR_ERR_MASK_TEMP_VR 8'h54
`define SEB_ADDR_ERR_MASK_VOLT    8'h55

// Widths of the two status registers
`define SEB_TEMP_VR_BITS          6
`define SEB_VOLT_BITS             8

// Field positions in the temperature / regulator status register
`define SEB_BIT_ZONE1             0
`define SEB_BIT_ZONE2             1
`define SEB_BIT_ZONE3             2
`define SEB_BIT_ZONE4             3
`define SEB_BIT_VR1               4
`define SEB_BIT_VR2               5

// Field positions in the control register
`define SEB_BIT_ALERT_EN          0
`define SEB_BIT_ASF_MODE          1
`define SEB_BIT_SUMMARY           7

// Field positions in the sleep mask registers
`define SEB_BIT_MASK_ZONE1        0
`define SEB_BIT_MASK_ZONE2        1

// Reset values
`define SEB_RST_STATUS            8'h00
`define SEB_RST_CTRL              8'h00
`define SEB_RST_SLEEP_STATE       2'b00
`define SEB_RST_SLEEP_MASK        2'b00
`define SEB_RST_ERR_MASK          8'h00
`define SEB_RST_RDATA             8'h00
`define SEB_ALERT_N_IDLE          1'b1

`endif

// [inc/seb_pkg.sv]
// Types shared by the sticky error bank and its bench
package seb_pkg;

    // Sleep state as written by the host; 2'b10 is not a legal code
    typedef enum logic [1:0] {
        SEB_SLEEP_S0  = 2'b00,
        SEB_SLEEP_S3  = 2'b01,
        SEB_SLEEP_S45 = 2'b11
    } seb_sleep_t;

    // One register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } seb_bus_req_t;

    // Error events from the comparators on this clock
    typedef struct packed {
        logic [3:0] zone_temp;
        logic [7:0] voltage;
    } seb_events_t;

    // Whole state of the bank top
    typedef struct packed {
        logic [1:0] hot_sync1;
        logic [1:0] hot_sync2;
        logic       alert_en;
        logic       asf_mode;
        seb_sleep_t sleep_state;
        logic [1:0] s3_mask;
        logic [1:0] s45_mask;
        logic [7:0] err_mask_temp_vr;
        logic [7:0] err_mask_volt;
        logic [7:0] rdata;
        logic       summary;
        logic       alert_n;
    } seb_state_t;

    // Whole state of one sticky register
    typedef struct packed {
        logic [7:0] bits;
    } seb_sticky_state_t;

endpackage : seb_pkg

// [hdl/seb_sticky_reg.sv]
// One register of sticky error bits with masked set and write-one clear
`timescale 1ns/1ps
`default_nettype none
`include "seb_defs.svh"

module seb_sticky_reg #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // Event and mask inputs
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic [WIDTH-1:0] mask_in,
    // Clear request, one bit per status bit
    input  wire logic [WIDTH-1:0] clear_in,
    // Sticky status
    output logic      [WIDTH-1:0] status
);

    seb_pkg::seb_sticky_state_t state_reg;
    seb_pkg::seb_sticky_state_t state_next;
    logic [WIDTH-1:0]           set_bits;

    ////////////////////////////////////////////////////////////////////////
    // Set and clear
    always_comb begin
        state_next = state_reg;
        // Only unmasked events may set a bit
        set_bits = event_in & ~mask_in;
        // Clear bit by bit; a live unmasked event wins over the clear
        state_next.bits[WIDTH-1:0] =
            (state_reg.bits[WIDTH-1:0] & ~clear_in) | set_bits;
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg <= `SEB_RST_STATUS;
        end else begin
            state_reg <= state_next;
        end
    end

    assign status = state_reg.bits[WIDTH-1:0];

endmodule // seb_sticky_reg

`default_nettype wire

// [verification/seb_bank_chk.sv]
// Port-level assertions for the sticky error status bank
`timescale 1ns/1ps
`default_nettype none
module seb_bank_chk (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  reset_n,
    // Register bus
    input wire seb_pkg::seb_bus_req_t bus_req,
    input wire logic [7:0]            rdata,
    // Fault inputs
    input wire seb_pkg::seb_events_t  fault_events,
    input wire logic                  regulator1_hot_input,
    input wire logic                  regulator2_hot_input_n,
    // Status outputs
    input wire logic                  error_summary_flag,
    input wire logic                  alert_n
);
    logic       alert_en_q;
    logic       asf_q;
    logic [1:0] sleep_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of control and sleep registers, taken from bus writes
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            alert_en_q <= 1'b0;
            asf_q      <= 1'b0;
            sleep_q    <= 2'b00;
        end else if (bus_req.wr && bus_req.addr == 8'h50) begin
            alert_en_q <= bus_req.wdata[0];
            asf_q      <= bus_req.wdata[1];
        end else if (bus_req.wr && bus_req.addr == 8'h51) begin
            sleep_q    <= bus_req.wdata[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after a read
    rdata_idle_a:
    assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    rsvd_bits_a:
    assert property ($past(bus_req.rd && bus_req.addr == 8'h40)
        |-> rdata[7:6] == 2'b00) else $error("reserved bits read nonzero");
    unmapped_rd_a:
    assert property ($past(bus_req.rd && !(bus_req.addr inside
        {8'h40, 8'h41, [8'h50:8'h55]})) |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    sticky_hold_a:
    assert property ($fell(error_summary_flag) |-> $past(bus_req.wr, 2)
        || ($past(bus_req.rd, 2) && $past(asf_q, 2)))
        else $error("summary fell without a clear");
    summary_cause_a:
    assert property ($rose(error_summary_flag) |-> $past(|fault_events, 2)
        || $past(regulator1_hot_input, 4) || !$past(regulator2_hot_input_n, 4))
        else $error("summary rose without a fault");
    alert_follow_a:
    assert property (!alert_n == ($past(alert_en_q) && error_summary_flag))
        else $error("alert output disagrees with summary and enable");
    ctrl_readback_a:
    assert property ($past(bus_req.rd && bus_req.addr == 8'h50)
        |-> rdata[1:0] == {$past(asf_q), $past(alert_en_q)})
        else $error("control bits read back wrong");
    sleep_only_zone_a:
    assert property ($rose(error_summary_flag) && $past(sleep_q[0], 2)
        |-> $past(|fault_events.zone_temp, 2))
        else $error("masked fault raised summary while asleep");
endmodule // seb_bank_chk
bind seb_bank seb_bank_chk u_chk (
    .clk_sys                (clk_sys),
    .reset_n                (reset_n),
    .bus_req                (bus_req),
    .rdata                  (rdata),
    .fault_events           (fault_events),
    .regulator1_hot_input   (regulator1_hot_input),
    .regulator2_hot_input_n (regulator2_hot_input_n),
    .error_summary_flag     (error_summary_flag),
    .alert_n                (alert_n)
);
`default_nettype wire

// [verification/seb_host_model.sv]
// Management controller model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module seb_host_model (
    // Clock
    input  wire logic                 clk_sys,
    // Register bus
    input  wire logic [7:0]           rdata,
    output var seb_pkg::seb_bus_req_t bus_req
);
    initial bus_req = '0;
    ////////////////////////////////////////////////////////////////////////
    // One-cycle write; idle address and data show garbage afterwards
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    // One-cycle read; data taken in the following cycle
    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h5a, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req <= '{addr: ~a, wdata: 8'ha5, wr: 1'b0, rd: 1'b0};
        @(negedge clk_sys);
        d = rdata;
    endtask
    // Host reports the system sleep state
    task automatic set_sleep(input seb_pkg::seb_sleep_t s);
        bus_write(8'h51, {6'h00, s});
    endtask
endmodule // seb_host_model
`default_nettype wire

// [verification/seb_bank_tb.sv]
// Self-checking bench for the sticky error status bank
`timescale 1ns/1ps
`default_nettype none
module seb_bank_tb;
    logic                  clk_sys = 1'b0;
    logic                  reset_n = 1'b0;
    seb_pkg::seb_bus_req_t bus_req;
    logic [7:0]            rdata;
    seb_pkg::seb_events_t  ev = '0;
    logic                  hot1 = 1'b0;
    logic                  hot2_n = 1'b1;
    logic                  summary;
    logic                  alert_n;
    int                    errors = 0;
    int                    compares = 0;
    always #5 clk_sys = ~clk_sys;
    seb_bank u_dut (
        .clk_sys                (clk_sys),
        .reset_n                (reset_n),
        .bus_req                (bus_req),
        .rdata                  (rdata),
        .fault_events           (ev),
        .regulator1_hot_input   (hot1),
        .regulator2_hot_input_n (hot2_n),
        .error_summary_flag     (summary),
        .alert_n                (alert_n)
    );
    seb_host_model u_host (
        .clk_sys (clk_sys),
        .rdata   (rdata),
        .bus_req (bus_req)
    );
    ////////////////////////////////////////////////////////////////////////
    // Compare helpers
    task automatic check_byte(input string w, input logic [7:0] e,
                              input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic check_bit(input string w, input logic e, input logic g);
        check_byte(w, {7'h00, e}, {7'h00, g});
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e,
                           input string w);
        logic [7:0] d;
        u_host.bus_read(a, d);
        check_byte(w, e, d);
    endtask
    task automatic pulse(input logic [3:0] z, input logic [7:0] v);
        @(posedge clk_sys);
        ev <= '{zone_temp: z, voltage: v};
        @(posedge clk_sys);
        ev <= '0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_values;
        logic [7:0] adr [9] = '{8'h40, 8'h41, 8'h50, 8'h51, 8'h52, 8'h53,
                                8'h54, 8'h55, 8'h00};
        u_host.bus_write(8'h7f, 8'hff);
        foreach (adr[i]) chk_reg(adr[i], 8'h00, "reset value");
        chk_reg(8'h7f, 8'h00, "unmapped");
        check_bit("alert idle", 1'b1, alert_n);
    endtask
    task automatic t_sticky(input logic [7:0] a, input int i);
        logic [7:0] m;
        m = 8'h01 << i;
        pulse(m[3:0] & {4{a == 8'h40}}, m & {8{a == 8'h41}});
        chk_reg(a, m, "status set");
        chk_reg(a, m, "status kept");
        check_bit("summary set", 1'b1, summary);
        u_host.bus_write(a, ~m);
        chk_reg(a, m, "zero write");
        u_host.bus_write(a, m);
        chk_reg(a, 8'h00, "w1c");
        check_bit("summary clear", 1'b0, summary);
    endtask
    task automatic t_hot;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys);
            hot1 <= (p == 0);
            hot2_n <= (p == 0);
            settle(5);
            chk_reg(8'h40, 8'h10 << p, "hot bit");
            @(posedge clk_sys);
            hot1 <= 1'b0;
            hot2_n <= 1'b1;
            settle(4);
            u_host.bus_write(8'h40, 8'h30);
            chk_reg(8'h40, 8'h00, "hot cleared");
        end
    endtask
    task automatic t_persist;
        @(posedge clk_sys);
        ev.zone_temp <= 4'h4;
        u_host.bus_write(8'h40, 8'h04);
        chk_reg(8'h40, 8'h04, "clear refused");
        u_host.bus_write(8'h54, 8'h04);
        chk_reg(8'h54, 8'h04, "error mask");
        u_host.bus_write(8'h40, 8'h04);
        chk_reg(8'h40, 8'h00, "masked clear");
        @(posedge clk_sys);
        ev <= '0;
        u_host.bus_write(8'h54, 8'h00);
        u_host.bus_write(8'h55, 8'h81);
        pulse(4'h0, 8'hff);
        chk_reg(8'h41, 8'h7e, "volt mask");
        u_host.bus_write(8'h41, 8'h7e);
        u_host.bus_write(8'h55, 8'h00);
    endtask
    task automatic t_asf;
        u_host.bus_write(8'h50, 8'h02);
        chk_reg(8'h50, 8'h02, "ctrl asf");
        pulse(4'h1, 8'h80);
        chk_reg(8'h40, 8'h01, "asf first read");
        chk_reg(8'h40, 8'h00, "asf read clear");
        u_host.bus_write(8'h41, 8'h80);
        chk_reg(8'h41, 8'h00, "asf w1c");
        u_host.bus_write(8'h50, 8'h00);
    endtask
    task automatic t_alert;
        u_host.bus_write(8'h50, 8'h01);
        pulse(4'h8, 8'h00);
        settle(2);
        check_bit("alert on", 1'b0, alert_n);
        chk_reg(8'h50, 8'h81, "ctrl summary");
        u_host.bus_write(8'h50, 8'h00);
        settle(2);
        check_bit("alert off", 1'b1, alert_n);
        u_host.bus_write(8'h40, 8'h08);
        settle(2);
        check_bit("summary off", 1'b0, summary);
    endtask
    task automatic t_sleep;
        u_host.set_sleep(seb_pkg::SEB_SLEEP_S3);
        chk_reg(8'h51, 8'h01, "sleep state");
        @(posedge clk_sys);
        hot1 <= 1'b1;
        hot2_n <= 1'b0;
        pulse(4'hf, 8'hff);
        settle(4);
        chk_reg(8'h41, 8'h00, "s3 volt");
        chk_reg(8'h40, 8'h0f, "s3 zones");
        @(posedge clk_sys);
        hot1 <= 1'b0;
        hot2_n <= 1'b1;
        u_host.bus_write(8'h40, 8'h0f);
        u_host.bus_write(8'h52, 8'h03);
        pulse(4'hf, 8'h00);
        chk_reg(8'h40, 8'h0c, "s3 masked");
        u_host.bus_write(8'h40, 8'h0c);
        u_host.set_sleep(seb_pkg::SEB_SLEEP_S45);
        u_host.bus_write(8'h53, 8'h02);
        pulse(4'hf, 8'hff);
        chk_reg(8'h41, 8'h00, "s45 volt");
        chk_reg(8'h40, 8'h0d, "s45 zones");
        u_host.bus_write(8'h40, 8'h0d);
        u_host.bus_write(8'h51, 8'h02);
        chk_reg(8'h51, 8'h02, "odd sleep state");
        pulse(4'h0, 8'hff);
        chk_reg(8'h41, 8'hff, "awake volt");
        u_host.bus_write(8'h41, 8'hff);
        u_host.set_sleep(seb_pkg::SEB_SLEEP_S0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic tally_and_finish;
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset_values();
        for (int i = 0; i < 4; i++) t_sticky(8'h40, i);
        for (int i = 0; i < 8; i++) t_sticky(8'h41, i);
        t_hot();
        t_persist();
        t_asf();
        t_alert();
        t_sleep();
        tally_and_finish();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        tally_and_finish();
    end
endmodule // seb_bank_tb
`default_nettype wire
